/* src/ble_telegram_tx_sequencer.sv */
// Telegram repetition sequencer and frame serializer
// How it works
// RULE1: Three modes: all advertising, data user-defined, or all user-defined.
// RULE2: Mode and user sequence come from the sequence select register.
// RULE3: Three-channel: first, second, third selected channel back to back.
// RULE4: Three-channel group sent three times per telegram.
// RULE5: Group spacing 20 ms by default, 10 ms when short gap set.
// RULE6: Two-channel: first then second channel, pair sent four times.
// RULE7: One-channel: six sends on first selected channel.
// RULE8: Each frame starts with preamble byte 0xaa.
// RULE9: Access address 0x8e89bed6 follows the preamble.
// RULE10: Six-byte source address in each frame.
// RULE11: Static address by default; private when privacy flag is one. Code uses static address for commissioning even with flag set.
// RULE12: Static address constant; private address new per telegram.
// RULE13: Upper 16 address bits are a fixed type code, not writable.
// RULE14: Lower 32 address bits are software writable.
// RULE15: Static address readable and writable over the register bus.
// RULE16: Sends within a group follow back to back, no gap.
// RULE17: Whitening seed is channel index, or MHz offset for custom channels.
// RULE18: Frame ends with three-byte check over header, address, payload.
// RULE19: Field order preamble, access, header, address, payload, check.
// RULE20: Commissioning on advertising channels always uses default pattern.
`timescale 1ns/1ns
`include "bltx_map.svh"
module ble_telegram_tx_sequencer (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Telegram request
    input wire logic TG_START,
    input wire logic TG_COMMISSION,
    input wire logic [15:0] TG_HEADER,
    input wire logic [5:0] TG_LEN,
    output logic TG_BUSY,
    // Payload fetch
    output logic [4:0] PL_INDEX,
    input wire logic [7:0] PL_DATA,
    // Radio byte stream
    output bltx_pkg::bltx_byte_t RF_BYTE,
    output logic RF_VALID,
    input wire logic RF_READY,
    output bltx_pkg::bltx_chan_t RF_CHAN
);
    typedef enum logic [2:0] {ST_IDLE, ST_FRAME, ST_NEXT, ST_GAP} bltx_st_t;
    typedef enum logic [2:0] {F_PRE, F_ACC, F_HDR, F_ADDR, F_PL, F_CRC} bltx_fld_t;
    // Register state
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [20:0] chan_r, chan_nxt;
    logic [31:0] addr_lo_r, addr_lo_nxt;
    logic [23:0] prand_r, prand_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    // Sequencer state
    bltx_st_t st_r, st_nxt;
    bltx_fld_t fld_r, fld_nxt;
    logic [2:0] bidx_r, bidx_nxt;
    logic [4:0] pidx_r, pidx_nxt;
    logic [1:0] slot_r, slot_nxt;
    logic [2:0] rep_r, rep_nxt;
    logic [20:0] gap_r, gap_nxt;
    logic use_adv_r, use_adv_nxt;
    bltx_pkg::bltx_seq_t seq_r, seq_nxt;
    logic [47:0] src_r, src_nxt;
    logic [15:0] hdr_r, hdr_nxt;
    logic [5:0] len_r, len_nxt;
    bltx_pkg::bltx_byte_t byte_r, byte_nxt;
    logic valid_r, valid_nxt;
    bltx_pkg::bltx_chan_t chan_out_r, chan_out_nxt;
    logic busy_r, busy_nxt;
    // Helpers
    bltx_pkg::bltx_mode_t mode;
    bltx_pkg::bltx_chan_t slot_sel;
    logic [23:0] crc;
    logic crc_init, crc_en;
    logic [2:0] slots_in_group, groups;
    logic [7:0] cur_byte;
    logic last_byte;
    logic take;
    // A literal cannot be part-selected, so the access word lives here
    localparam logic [31:0] acc_word = `BLTX_ACCESS_ADDR;

    assign mode = bltx_pkg::bltx_mode_t'(ctrl_r[`BLTX_CTRL_MODE_LSB +: 2]);
    assign take = valid_r && RF_READY;

    bltx_slot u_slot (
        .slot(slot_r),
        .use_adv(use_adv_r),
        .user_chans(chan_r),
        .sel(slot_sel)
    );

    bltx_crc u_crc (
        .clk(REF_CLK),
        .nrst(NRST),
        .init(crc_init),
        .en(crc_en),
        .din(cur_byte),
        .crc(crc)
    );

    // Register bus: one wait cycle on every access
    always_comb begin
        ctrl_nxt = ctrl_r;
        chan_nxt = chan_r;
        addr_lo_nxt = addr_lo_r;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        if ((AVS_READ || AVS_WRITE) && wait_r) begin
            wait_nxt = 1'b0;
            rdata_nxt = 32'h0000_0000;
            unique case (AVS_ADDRESS)
                // RULE2 sequence select register
                `BLTX_OFF_CTRL: rdata_nxt = {26'h0, ctrl_r[5:0]};
                `BLTX_OFF_CHAN: rdata_nxt = {11'h0, chan_r};
                // RULE15 address readback
                `BLTX_OFF_ADDR_LO: rdata_nxt = addr_lo_r;
                `BLTX_OFF_ADDR_HI: rdata_nxt = {16'h0, `BLTX_TYPE_CODE};
                `BLTX_OFF_PRAND: rdata_nxt = {8'h0, prand_r};
                `BLTX_OFF_STATUS: rdata_nxt = {27'h0, busy_r, rep_r, 1'b0};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // Write lands only at the edge where waitrequest is seen low
        if (AVS_WRITE && !wait_r) begin
            unique case (AVS_ADDRESS)
                `BLTX_OFF_CTRL: ctrl_nxt = {26'h0, AVS_WRITEDATA[5:0]};
                `BLTX_OFF_CHAN: chan_nxt = AVS_WRITEDATA[20:0];
                // RULE14 writable low word
                `BLTX_OFF_ADDR_LO: addr_lo_nxt = AVS_WRITEDATA;
                // RULE13 type code write ignored
                default: ctrl_nxt = ctrl_r;
            endcase
        end
    end

    // Sequencing and serialising
    always_comb begin
        st_nxt = st_r;
        fld_nxt = fld_r;
        bidx_nxt = bidx_r;
        pidx_nxt = pidx_r;
        slot_nxt = slot_r;
        rep_nxt = rep_r;
        gap_nxt = gap_r;
        use_adv_nxt = use_adv_r;
        seq_nxt = seq_r;
        src_nxt = src_r;
        hdr_nxt = hdr_r;
        len_nxt = len_r;
        prand_nxt = prand_r;
        byte_nxt = byte_r;
        valid_nxt = valid_r;
        chan_out_nxt = chan_out_r;
        busy_nxt = busy_r;
        crc_init = 1'b0;
        crc_en = 1'b0;
        cur_byte = 8'h00;
        last_byte = 1'b0;
        // RULE19 field order
        unique case (fld_r)
            F_PRE: cur_byte = `BLTX_PREAMBLE;
            F_ACC: cur_byte = acc_word[8*bidx_r +: 8];
            F_HDR: cur_byte = hdr_r[8*bidx_r +: 8];
            F_ADDR: cur_byte = src_r[8*bidx_r +: 8];
            F_PL: cur_byte = PL_DATA;
            F_CRC: begin
                cur_byte = crc[8*bidx_r +: 8];
                last_byte = (bidx_r == 3'd2);
            end
            default: cur_byte = 8'h00;
        endcase
        slots_in_group = (seq_r == bltx_pkg::BLTX_SEQ_TWO) ? 3'd2 : (seq_r == bltx_pkg::BLTX_SEQ_ONE) ? 3'd1 : 3'd3;
        groups = (seq_r == bltx_pkg::BLTX_SEQ_TWO) ? 3'd4 : (seq_r == bltx_pkg::BLTX_SEQ_ONE) ? 3'd6 : 3'd3;
        unique case (st_r)
            ST_IDLE: begin
                if (TG_START) begin
                    busy_nxt = 1'b1;
                    // RULE1 mode decode
                    // RULE20 commissioning on advertising pattern
                    use_adv_nxt = (mode == bltx_pkg::BLTX_MODE_ADV) || (mode == bltx_pkg::BLTX_MODE_RSVD)
                        || (TG_COMMISSION && mode == bltx_pkg::BLTX_MODE_DATA_USER);
                    seq_nxt = use_adv_nxt ? bltx_pkg::BLTX_SEQ_THREE
                        : bltx_pkg::bltx_seq_t'(ctrl_r[`BLTX_CTRL_SEQ_LSB +: 2]);
                    // RULE11 address mode
                    // RULE12 fresh private address per telegram, commissioning stays static
                    if (ctrl_r[`BLTX_CTRL_PRIV_BIT] && !TG_COMMISSION) begin
                        prand_nxt = {prand_r[22:0], prand_r[23] ^ prand_r[22] ^ prand_r[21] ^ prand_r[16]};
                        src_nxt = {2'b10, prand_nxt[21:0], prand_nxt ^ addr_lo_r[23:0]};
                    end else begin
                        // RULE13 fixed type code on top
                        src_nxt = {`BLTX_TYPE_CODE, addr_lo_r};
                    end
                    hdr_nxt = TG_HEADER;
                    len_nxt = (TG_LEN > `BLTX_MAX_PAYLOAD) ? `BLTX_MAX_PAYLOAD : TG_LEN;
                    slot_nxt = 2'd0;
                    rep_nxt = 3'd0;
                    st_nxt = ST_FRAME;
                    fld_nxt = F_PRE;
                    bidx_nxt = 3'd0;
                    pidx_nxt = 5'd0;
                end
            end
            ST_FRAME: begin
                chan_out_nxt = slot_sel;
                if (!valid_r || take) begin
                    // RULE8 preamble first
                    byte_nxt = '{data: cur_byte, first: (fld_r == F_PRE), last: last_byte};
                    valid_nxt = 1'b1;
                    // RULE18 check covers header, address and payload
                    crc_init = (fld_r == F_PRE);
                    crc_en = (fld_r == F_HDR) || (fld_r == F_ADDR) || (fld_r == F_PL);
                    bidx_nxt = bidx_r + 3'd1;
                    unique case (fld_r)
                        F_PRE: begin
                            fld_nxt = F_ACC;
                            bidx_nxt = 3'd0;
                        end
                        // RULE9 access address after preamble
                        F_ACC: if (bidx_r == 3'd3) begin
                            fld_nxt = F_HDR;
                            bidx_nxt = 3'd0;
                        end
                        F_HDR: if (bidx_r == 3'd1) begin
                            fld_nxt = F_ADDR;
                            bidx_nxt = 3'd0;
                        end
                        // RULE10 six address bytes
                        F_ADDR: if (bidx_r == 3'd5) begin
                            fld_nxt = (len_r == 6'd0) ? F_CRC : F_PL;
                            bidx_nxt = 3'd0;
                        end
                        F_PL: begin
                            bidx_nxt = 3'd0;
                            pidx_nxt = pidx_r + 5'd1;
                            if (6'(pidx_r) + 6'd1 == len_r) begin
                                fld_nxt = F_CRC;
                            end
                        end
                        F_CRC: if (last_byte) begin
                            st_nxt = ST_NEXT;
                        end
                        default: fld_nxt = F_PRE;
                    endcase
                end
            end
            ST_NEXT: begin
                if (take) begin
                    valid_nxt = 1'b0;
                    fld_nxt = F_PRE;
                    bidx_nxt = 3'd0;
                    pidx_nxt = 5'd0;
                    // RULE16 next slot back to back
                    if (3'(slot_r) + 3'd1 < slots_in_group) begin
                        // RULE3 next selected channel
                        slot_nxt = slot_r + 2'd1;
                        st_nxt = ST_FRAME;
                    end else if (rep_r + 3'd1 < groups) begin
                        // RULE4 RULE6 RULE7 group repeat count
                        rep_nxt = rep_r + 3'd1;
                        slot_nxt = 2'd0;
                        // RULE5 group spacing
                        gap_nxt = ctrl_r[`BLTX_CTRL_SHORT_BIT] ? 21'(`BLTX_GAP_SHORT_CYC) : 21'(`BLTX_GAP_LONG_CYC);
                        st_nxt = ST_GAP;
                    end else begin
                        busy_nxt = 1'b0;
                        st_nxt = ST_IDLE;
                    end
                end
            end
            ST_GAP: begin
                gap_nxt = gap_r - 21'd1;
                if (gap_r <= 21'd1) begin
                    st_nxt = ST_FRAME;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            ctrl_r <= `BLTX_CTRL_RST;
            chan_r <= `BLTX_CHAN_RST;
            addr_lo_r <= `BLTX_ADDR_LO_RST;
            prand_r <= `BLTX_PRAND_RST;
            rdata_r <= 32'h0000_0000;
            wait_r <= 1'b1;
            st_r <= ST_IDLE;
            fld_r <= F_PRE;
            bidx_r <= 3'd0;
            pidx_r <= 5'd0;
            slot_r <= 2'd0;
            rep_r <= 3'd0;
            gap_r <= 21'd0;
            use_adv_r <= 1'b1;
            seq_r <= bltx_pkg::BLTX_SEQ_THREE;
            src_r <= 48'h0;
            hdr_r <= 16'h0;
            len_r <= 6'd0;
            byte_r <= '0;
            valid_r <= 1'b0;
            chan_out_r <= '0;
            busy_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            chan_r <= chan_nxt;
            addr_lo_r <= addr_lo_nxt;
            prand_r <= prand_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            st_r <= st_nxt;
            fld_r <= fld_nxt;
            bidx_r <= bidx_nxt;
            pidx_r <= pidx_nxt;
            slot_r <= slot_nxt;
            rep_r <= rep_nxt;
            gap_r <= gap_nxt;
            use_adv_r <= use_adv_nxt;
            seq_r <= seq_nxt;
            src_r <= src_nxt;
            hdr_r <= hdr_nxt;
            len_r <= len_nxt;
            byte_r <= byte_nxt;
            valid_r <= valid_nxt;
            chan_out_r <= chan_out_nxt;
            busy_r <= busy_nxt;
        end
    end

    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign TG_BUSY = busy_r;
    assign PL_INDEX = pidx_r;
    assign RF_BYTE = byte_r;
    assign RF_VALID = valid_r;
    assign RF_CHAN = chan_out_r;

    // RULE8 preamble value on first byte
    preamble_val_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        RF_VALID && RF_BYTE.first |-> RF_BYTE.data == 8'haa) else $error("bad preamble"); // RULE8
    // RULE9 access address low byte next
    access_first_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        take && RF_BYTE.first |=> RF_VALID && RF_BYTE.data == 8'hd6) else $error("bad access byte"); // RULE9
    // RULE13 type code readback fixed
    type_code_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 4'h3 |-> AVS_READDATA == 32'h0000_5a5a)
        else $error("type code changed"); // RULE13
    // RULE16 no gap inside group
    group_tight_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_r == ST_NEXT && take && slot_r == 2'd0 && slots_in_group > 3'd1 |=> st_r == ST_FRAME)
        else $error("gap inside group"); // RULE16
    // RULE5 gap length loaded
    gap_load_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        $rose(st_r == ST_GAP) |-> gap_r == 21'd1000000 || gap_r == 21'd500000) else $error("bad gap"); // RULE5
    // RULE4 repeat bound
    rep_bound_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        rep_r < groups || st_r == ST_IDLE) else $error("too many groups"); // RULE4
    // RULE20 commissioning default pattern
    comm_adv_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        st_r == ST_IDLE && TG_START && TG_COMMISSION && mode == bltx_pkg::BLTX_MODE_DATA_USER |=> use_adv_r)
        else $error("commissioning not on adv"); // RULE20
    // RULE15 waitrequest drops in the same or the next cycle
    bus_answer_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (AVS_READ || AVS_WRITE) |-> ##[0:1] !AVS_WAITREQUEST) else $error("bus hang"); // RULE15
    telegram_c: cover property (@(posedge REF_CLK) disable iff (!NRST) $fell(busy_r));
    gap_c: cover property (@(posedge REF_CLK) disable iff (!NRST) $rose(st_r == ST_GAP));
    one_chan_c: cover property (@(posedge REF_CLK) disable iff (!NRST) seq_r == bltx_pkg::BLTX_SEQ_ONE && rep_r == 3'd5);
endmodule

/* src/bltx_map.svh */
// Offsets, field positions, reset values and timing counts of the telegram sequencer
`ifndef BLTX_MAP_SVH
`define BLTX_MAP_SVH
// Register word offsets
`define BLTX_OFF_CTRL 4'h0
`define BLTX_OFF_CHAN 4'h1
`define BLTX_OFF_ADDR_LO 4'h2
`define BLTX_OFF_ADDR_HI 4'h3
`define BLTX_OFF_PRAND 4'h4
`define BLTX_OFF_STATUS 4'h5
// Control field positions
`define BLTX_CTRL_MODE_LSB 0
`define BLTX_CTRL_SEQ_LSB 2
`define BLTX_CTRL_SHORT_BIT 4
`define BLTX_CTRL_PRIV_BIT 5
// Reset values
`define BLTX_CTRL_RST 32'h0000_0000
`define BLTX_CHAN_RST 21'h09d325
`define BLTX_PRAND_RST 24'h800001
`define BLTX_ADDR_LO_RST 32'h0000_0001
// Product type code, arbitrary neutral value
`define BLTX_TYPE_CODE 16'h5a5a
// Frame constants
`define BLTX_PREAMBLE 8'haa
`define BLTX_ACCESS_ADDR 32'h8e89bed6
`define BLTX_CRC_INIT 24'h555555
`define BLTX_CRC_POLY 24'h00065b
`define BLTX_MAX_PAYLOAD 6'd31
`define BLTX_NUM_ADV 8'd37
// Timing
`define BLTX_CLK_HZ 50000000
`define BLTX_GAP_LONG_MS 20
`define BLTX_GAP_SHORT_MS 10
`define BLTX_GAP_LONG_CYC (`BLTX_GAP_LONG_MS * (`BLTX_CLK_HZ / 1000))
`define BLTX_GAP_SHORT_CYC (`BLTX_GAP_SHORT_MS * (`BLTX_CLK_HZ / 1000))
`endif

/* src/bltx_pkg.sv */
// Types of the telegram sequencer
package bltx_pkg;
    typedef enum logic [1:0] {BLTX_MODE_ADV, BLTX_MODE_DATA_USER, BLTX_MODE_ALL_USER, BLTX_MODE_RSVD} bltx_mode_t;
    typedef enum logic [1:0] {BLTX_SEQ_THREE, BLTX_SEQ_TWO, BLTX_SEQ_ONE, BLTX_SEQ_RSVD} bltx_seq_t;
    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
    } bltx_byte_t;
    typedef struct packed {
        logic [6:0] chan;
        logic [6:0] white;
    } bltx_chan_t;
endpackage

/* src/bltx_crc.sv */
// Serial 24-bit frame check over one byte per cycle
`timescale 1ns/1ns
`include "bltx_map.svh"
module bltx_crc (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Byte feed
    input wire logic init,
    input wire logic en,
    input wire logic [7:0] din,
    // Result
    output logic [23:0] crc
);
    logic [23:0] crc_r;
    logic [23:0] crc_nxt;
    logic [23:0] c;
    always_comb begin
        c = crc_r;
        for (int i = 0; i < 8; i++) begin
            if (c[23] ^ din[i]) begin
                c = {c[22:0], 1'b0} ^ `BLTX_CRC_POLY;
            end else begin
                c = {c[22:0], 1'b0};
            end
        end
        crc_nxt = crc_r;
        if (init) begin
            crc_nxt = `BLTX_CRC_INIT;
        end else if (en) begin
            crc_nxt = c;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            crc_r <= `BLTX_CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end
    assign crc = crc_r;
endmodule

/* src/bltx_slot.sv */
// Picks the channel and whitening seed of one transmission slot
`timescale 1ns/1ns
`include "bltx_map.svh"
module bltx_slot (
    // Selection
    input wire logic [1:0] slot,
    input wire logic use_adv,
    input wire logic [20:0] user_chans,
    // Result
    output bltx_pkg::bltx_chan_t sel
);
    logic [6:0] ch;
    always_comb begin
        ch = 7'(`BLTX_NUM_ADV + 8'(slot));
        if (!use_adv) begin
            ch = user_chans[7*slot +: 7];
        end
        sel.chan = ch;
        // RULE17 whitening seed choice
        if (ch <= 7'd39) begin
            sel.white = ch;
        end else begin
            sel.white = 7'(2 * (ch - 7'd40) + 3);
        end
    end
endmodule

/* tb/bltx_rx_model.sv */
// Behavioural radio receiver that collects the sent frames
`timescale 1ns/1ns
module bltx_rx_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Radio byte stream
    input wire bltx_pkg::bltx_byte_t rf_byte,
    input wire logic rf_valid,
    output logic rf_ready,
    input wire bltx_pkg::bltx_chan_t rf_chan
);
    bltx_pkg::bltx_byte_t q[$];
    bltx_pkg::bltx_chan_t chq[$];
    int st[$];
    int cyc = 0;
    int nf = 0;
    // Slow mode takes a byte every other cycle, so frames stretch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rf_ready <= slow ? ~rf_ready : 1'b1;
        if (rf_valid && rf_ready) begin
            q.push_back(rf_byte);
            if (rf_byte.first) begin
                chq.push_back(rf_chan);
                st.push_back(cyc);
            end
            if (rf_byte.last) begin
                nf <= nf + 1;
            end
        end
    end
    task automatic clear();
        q.delete();
        chq.delete();
        st.delete();
        nf = 0;
    endtask
endmodule

/* tb/tb_ble_telegram_tx_sequencer.sv */
// Self-checking bench of the telegram sequencer
`timescale 1ns/1ns
`include "bltx_map.svh"
module tb_ble_telegram_tx_sequencer;
    logic REF_CLK, NRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, TG_START, TG_COMMISSION, TG_BUSY;
    logic RF_VALID, RF_READY, slow;
    logic [3:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
    logic [15:0] TG_HEADER;
    logic [5:0] TG_LEN;
    logic [4:0] PL_INDEX;
    logic [7:0] PL_DATA;
    bltx_pkg::bltx_byte_t RF_BYTE;
    bltx_pkg::bltx_chan_t RF_CHAN;
    int n_fail = 0;
    int tests_run = 0;
    // Payload source answers combinationally from the index
    assign PL_DATA = {3'h5, PL_INDEX};
    ble_telegram_tx_sequencer dut_u (.REF_CLK(REF_CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .TG_START(TG_START),
        .TG_COMMISSION(TG_COMMISSION), .TG_HEADER(TG_HEADER), .TG_LEN(TG_LEN), .TG_BUSY(TG_BUSY),
        .PL_INDEX(PL_INDEX), .PL_DATA(PL_DATA), .RF_BYTE(RF_BYTE), .RF_VALID(RF_VALID),
        .RF_READY(RF_READY), .RF_CHAN(RF_CHAN));
    bltx_rx_model rx_u (.clk(REF_CLK), .slow(slow), .rf_byte(RF_BYTE), .rf_valid(RF_VALID),
        .rf_ready(RF_READY), .rf_chan(RF_CHAN));
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One byte of the frame check, fed least significant bit first
    function automatic logic [23:0] crc_step(input logic [23:0] c, input logic [7:0] d);
        logic [23:0] r;
        r = c;
        for (int i = 0; i < 8; i++) r = {r[22:0], 1'b0} ^ ((r[23] ^ d[i]) ? `BLTX_CRC_POLY : 24'h0);
        return r;
    endfunction
    task automatic test_done();
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        AVS_ADDRESS <= a;
        AVS_WRITE <= wr;
        AVS_READ <= ~wr;
        AVS_WRITEDATA <= d;
        for (i = 0; i < 100; i++) begin
            @(posedge REF_CLK);
            if (AVS_WAITREQUEST === 1'b0) break;
        end
        rd = AVS_READDATA;
        if (i == 100) begin
            n_fail++;
            test_done();
        end
        AVS_READ <= 1'b0;
        AVS_WRITE <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic rst();
        NRST <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        NRST <= 1'b1;
        rx_u.clear();
        @(posedge REF_CLK);
    endtask
    // Gaps are far longer than the run, so only the first group is judged
    task automatic run(input logic [31:0] ctrl, input logic com, input logic [5:0] len, input int n,
                       input logic [20:0] ech, input logic [20:0] ewh, input logic priv);
        int i, k, j, fl, eff;
        logic [47:0] sa, ga, g0;
        logic [23:0] crc;
        logic [7:0] e;
        bltx_pkg::bltx_byte_t b;
        rst();
        bus(1'b1, `BLTX_OFF_ADDR_LO, 32'h1234abcd);
        bus(1'b1, `BLTX_OFF_CTRL, ctrl);
        bus(1'b1, `BLTX_OFF_CHAN, {11'h0, 7'd78, 7'd10, 7'd40});
        TG_START <= 1'b1;
        TG_COMMISSION <= com;
        TG_HEADER <= 16'hc342;
        TG_LEN <= len;
        @(posedge REF_CLK);
        TG_START <= 1'b0;
        for (i = 0; i < 20000 && rx_u.nf < n; i++) @(posedge REF_CLK);
        if (i == 20000) begin
            n_fail++;
            test_done();
        end
        repeat (3000) @(posedge REF_CLK);
        chk("frames before gap", 32'(rx_u.nf), 32'(n));
        chk("busy in gap", {31'h0, TG_BUSY}, 32'h1);
        eff = (len > 31) ? 31 : len;
        fl = 16 + eff;
        sa = {`BLTX_TYPE_CODE, 32'h1234abcd};
        if (rx_u.nf != n) return;
        for (k = 0; k < n; k++) begin
            chk("channel", {25'h0, rx_u.chq[k].chan}, {25'h0, ech[7 * k +: 7]});
            chk("whitening", {25'h0, rx_u.chq[k].white}, {25'h0, ewh[7 * k +: 7]});
            if (k > 0 && !slow) chk("spacing", 32'(rx_u.st[k] - rx_u.st[k - 1] <= fl + 3), 32'h1);
            for (j = 0; j < fl; j++) begin
                b = rx_u.q[k * fl + j];
                if (j == 0) crc = `BLTX_CRC_INIT;
                e = (j == 0) ? `BLTX_PREAMBLE : (j < 5) ? 8'(`BLTX_ACCESS_ADDR >> (8 * (j - 1))) :
                    (j < 7) ? 8'(16'hc342 >> (8 * (j - 5))) : (j < 13) ? 8'(sa >> (8 * (j - 7))) :
                    (j < 13 + eff) ? {3'h5, 5'(j - 13)} : crc[8 * (j - 13 - eff) +: 8];
                if (j > 6 && j < 13) ga[8 * (j - 7) +: 8] = b.data;
                if (priv && j > 6 && j < 13) e = b.data;
                chk("frame byte", {22'h0, b.data, b.first, b.last}, {22'h0, e, j == 0, j == fl - 1});
                if (j > 4 && j < 13 + eff) crc = crc_step(crc, e);
            end
            chk("private address", {31'h0, ga !== sa}, {31'h0, priv});
            if (k == 0) g0 = ga;
            chk("address per telegram", {31'h0, ga === g0}, 32'h1);
            if (priv) chk("private prefix", {30'h0, ga[47:46]}, 32'h2);
        end
        slow <= 1'b0;
    endtask
    task automatic s_regs();
        rst();
        bus(1'b0, `BLTX_OFF_ADDR_LO, 32'h0);
        chk("address low reset", rd, 32'h1);
        bus(1'b0, `BLTX_OFF_CTRL, 32'h0);
        chk("control reset", rd, 32'h0);
        bus(1'b0, `BLTX_OFF_CHAN, 32'h0);
        chk("channel reset", rd, {11'h0, 7'd39, 7'd38, 7'd37});
        bus(1'b1, `BLTX_OFF_ADDR_HI, 32'hffff);
        bus(1'b0, `BLTX_OFF_ADDR_HI, 32'h0);
        chk("type code", rd, {16'h0, `BLTX_TYPE_CODE});
        bus(1'b1, `BLTX_OFF_ADDR_LO, 32'hdeadbeef);
        bus(1'b0, `BLTX_OFF_ADDR_LO, 32'h0);
        chk("address low", rd, 32'hdeadbeef);
        bus(1'b0, 4'h9, 32'h0);
        chk("unmapped", rd, 32'h0);
    endtask
    task automatic s_adv();
        run(32'h0, 1'b0, 6'd3, 3, {7'd39, 7'd38, 7'd37}, {7'd39, 7'd38, 7'd37}, 1'b0);
    endtask
    task automatic s_commission();
        run(32'h1, 1'b1, 6'd40, 3, {7'd39, 7'd38, 7'd37}, {7'd39, 7'd38, 7'd37}, 1'b0);
    endtask
    task automatic s_user_three();
        slow <= 1'b1;
        run(32'h1, 1'b0, 6'd0, 3, {7'd78, 7'd10, 7'd40}, {7'd79, 7'd10, 7'd3}, 1'b0);
    endtask
    task automatic s_user_two();
        run(32'h6, 1'b0, 6'd5, 2, {7'd0, 7'd10, 7'd40}, {7'd0, 7'd10, 7'd3}, 1'b0);
    endtask
    task automatic s_user_one();
        run(32'ha, 1'b0, 6'd2, 1, {14'h0, 7'd40}, {14'h0, 7'd3}, 1'b0);
    endtask
    task automatic s_private();
        run(32'h30, 1'b0, 6'd1, 3, {7'd39, 7'd38, 7'd37}, {7'd39, 7'd38, 7'd37}, 1'b1);
    endtask
    initial begin
        NRST = 1'b0;
        AVS_ADDRESS = 4'h0;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_WRITEDATA = 32'h0;
        TG_START = 1'b0;
        TG_COMMISSION = 1'b0;
        TG_HEADER = 16'h0;
        TG_LEN = 6'h0;
        slow = 1'b0;
        repeat (4) @(posedge REF_CLK);
        NRST <= 1'b1;
        @(posedge REF_CLK);
        s_regs();
        s_adv();
        s_commission();
        s_user_three();
        s_user_two();
        s_user_one();
        s_private();
        test_done();
    end
endmodule
